// ### bench/tb_timer_timebase_capture_compare.sv
// self-checking bench for the timer core
module tb_timer_timebase_capture_compare;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'b00;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, q, v;
  logic        hreadyout, brk_in;
  logic [1:0]  ch_in, aux_in, ch_out, ch_oe, ch_out_n, ch_oe_n;
  int          err_total = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  int          t_last, c, hi;
  logic [7:0]  ra[7] = '{8'h00, 8'h08, 8'h0C, 8'h10, 8'h18, 8'h28, 8'h3C};
  logic [31:0] rv[7] = '{32'h0, 32'h0, 32'h0, 32'hFFFF, 32'h0, 32'h4, 32'h0};
  always #4 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  tbc_timer tbc_timer_i (.clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(), .ch_in(ch_in), .aux_in(aux_in),
    .brk_in(brk_in), .ch_out(ch_out), .ch_oe(ch_oe), .ch_out_n(ch_out_n), .ch_oe_n(ch_oe_n));
  tbc_pins tbc_pins_i (.clk(clk), .ch_in(ch_in), .aux_in(aux_in), .brk_in(brk_in));
  // ------------------------------
  // bus and check tasks
  // ------------------------------
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic ck(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  // one ahb-lite single transfer; read data lands in q
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr  <= {24'h0, a};
    do @(posedge clk); while (hreadyout !== 1'b1 && ++n < 50);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1 && ++n < 50);
    q = hrdata;
    ck(32'(n < 50), 32'h1);
    if (n >= 50) close_out();
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    ck(q, e);
  endtask
  // poll status until every bit of m is set; c is the gap since the last hit
  task automatic poll(input logic [31:0] m);
    int n;
    n = 0;
    do xfer(1'b0, 8'h04, 32'h0); while ((q & m) !== m && ++n < 100);
    c = cyc - t_last;
    t_last = cyc;
    ck(32'(n < 100), 32'h1);
    if (n >= 100) close_out();
  endtask
  // ------------------------------
  // scenarios
  // ------------------------------
  initial begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    xfer(1'b1, 8'h3C, 32'hFFFF_FFFF);
    foreach (ra[i]) rdc(ra[i], rv[i]);
    xfer(1'b1, 8'h10, 32'h9);
    xfer(1'b1, 8'h14, 32'h2);
    xfer(1'b1, 8'h00, 32'h1);
    poll(32'h1);
    xfer(1'b1, 8'h0C, 32'h1);
    // divider change lands only at the next update, so the second gap doubles
    for (int k = 0; k < 2; k++) begin
      xfer(1'b1, 8'h04, 32'h0);
      poll(32'h1);
      ck(32'(c >= (k ? 56 : 26) && c <= (k ? 64 : 34)), 32'h1);
    end
    xfer(1'b1, 8'h00, 32'h0);
    xfer(1'b0, 8'h08, 32'h0);
    v = q;
    repeat (9) @(posedge clk);
    rdc(8'h08, v);
    ck(32'(v <= 9), 32'h1);
    // two enabled clocks at divide-by-two give one tick: zero counting down reloads
    xfer(1'b1, 8'h08, 32'h0);
    xfer(1'b1, 8'h00, 32'h3);
    xfer(1'b1, 8'h00, 32'h2);
    rdc(8'h08, 32'h9);
    // frozen counter makes the captured value exact
    xfer(1'b1, 8'h08, 32'h1234);
    xfer(1'b1, 8'h18, 32'h75);
    xfer(1'b1, 8'h1C, 32'h1);
    xfer(1'b1, 8'h04, 32'h0);
    tbc_pins_i.pulse(3);
    tbc_pins_i.pulse(12);
    repeat (20) @(posedge clk);
    rdc(8'h04, 32'h0);
    tbc_pins_i.pulse(12);
    poll(32'h2);
    rdc(8'h20, 32'h1234);
    xfer(1'b1, 8'h1C, 32'h0);
    xfer(1'b1, 8'h18, 32'h0201);
    xfer(1'b1, 8'h1C, 32'h31);
    xfer(1'b1, 8'h18, 32'h0200);
    rdc(8'h18, 32'h0201);
    xfer(1'b1, 8'h08, 32'h55);
    xfer(1'b1, 8'h04, 32'h0);
    tbc_pins_i.pulse(4);
    repeat (20) @(posedge clk);
    rdc(8'h04, 32'h6);
    rdc(8'h20, 32'h55);
    rdc(8'h24, 32'h55);
    // on-chip source selected by direction 11 captures on its own rising edge
    xfer(1'b1, 8'h1C, 32'h0);
    xfer(1'b1, 8'h18, 32'h3);
    xfer(1'b1, 8'h08, 32'h66);
    xfer(1'b1, 8'h1C, 32'h1);
    xfer(1'b1, 8'h04, 32'h0);
    poll(32'h2);
    rdc(8'h20, 32'h66);
    xfer(1'b1, 8'h1C, 32'h0);
    xfer(1'b1, 8'h18, 32'h60);
    xfer(1'b1, 8'h20, 32'h3);
    xfer(1'b1, 8'h1C, 32'h5);
    xfer(1'b1, 8'h00, 32'h1);
    // duty over two periods; a broken complement or enable adds 100
    for (int m = 0; m < 3; m++) begin
      xfer(1'b1, 8'h18, (m == 2) ? 32'h50 : (m ? 32'h70 : 32'h60));
      repeat (45) @(posedge clk);
      hi = 0;
      repeat (40) begin
        @(negedge clk);
        hi += ch_out[0];
        if (ch_out_n[0] === ch_out[0] || {ch_oe[0], ch_oe_n[0]} !== 2'b11) hi += 100;
      end
      ck(32'(hi), (m == 2) ? 32'h28 : (m ? 32'h1C : 32'hC));
    end
    xfer(1'b1, 8'h28, 32'h7);
    tbc_pins_i.trip();
    repeat (4) @(negedge clk);
    ck({30'h0, ch_oe | ch_oe_n}, 32'h0);
    xfer(1'b0, 8'h04, 32'h0);
    ck({31'h0, q[3]}, 32'h1);
    close_out();
  end
endmodule

// ### bench/tbc_asserts.sv
// checker: bus timing and break response of the timer core
module tbc_asserts (
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        brk_in,
  input wire logic [1:0]  ch_oe,
  input wire logic [1:0]  ch_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       rd_go;
  logic       wr_go;
  logic       wr_r;
  logic [7:0] adr_r;
  logic [4:0] brk_r;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  assign rd_go = hsel && htrans[1] && hready && !hwrite;
  assign wr_go = hsel && htrans[1] && hready && hwrite;
  // shadow of the break word, so the break check only runs when armed
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr_r  <= 1'b0;
      adr_r <= 8'h00;
      brk_r <= 5'h04;
    end else if (hready) begin
      wr_r  <= wr_go;
      adr_r <= haddr[7:0];
      if (wr_r && adr_r == 8'h28)
        brk_r <= hwdata[4:0];
    end
  end
  // ------------------------------
  // checks
  // ------------------------------
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("error response seen");
  a_read_wait: assert property (rd_go |=> !hreadyout ##1 hreadyout)
    else $error("read not one wait state");
  a_write_fast: assert property (wr_go |=> hreadyout)
    else $error("write stalled");
  a_wait_once: assert property (!hreadyout |=> hreadyout)
    else $error("wait state too long");
  a_idle_ready: assert property (!$past(rd_go) |-> hreadyout)
    else $error("wait state without read");
  a_rdata_hold: assert property ($changed(hrdata) |-> !$past(hreadyout))
    else $error("read data moved");
  a_reset_off: assert property ($rose(rstn) |-> (ch_oe | ch_oe_n) == 2'b00)
    else $error("outputs driven after reset");
  a_brk_off:
    assert property (brk_r[0] && brk_r[1] && !brk_r[3] && $rose(brk_in) |->
      ##3 ((ch_oe | ch_oe_n) == 2'b00)[*4])
    else $error("break left outputs on");
endmodule

bind tbc_timer tbc_asserts tbc_asserts_i (
  .clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
  .hresp(hresp), .brk_in(brk_in), .ch_oe(ch_oe), .ch_oe_n(ch_oe_n));

// ### bench/tbc_pins.sv
// pin-side model: capture pulses, an on-chip square wave and the break pin
module tbc_pins (
  input wire logic  clk,
  output logic [1:0] ch_in,
  output logic [1:0] aux_in,
  output logic       brk_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] div_r = 4'h0;
  initial begin
    ch_in  = 2'b00;
    aux_in = 2'b00;
    brk_in = 1'b0;
  end
  // on-chip source runs free, like an oscillator tapped for calibration
  always @(posedge clk) begin
    div_r  <= div_r + 4'h1;
    aux_in <= {2{div_r[3]}};
  end
  // one pulse of len clocks; short ones must be swallowed by the filter
  task automatic pulse(input int len);
    @(posedge clk);
    ch_in[0] <= 1'b1;
    repeat (len) @(posedge clk);
    ch_in[0] <= 1'b0;
  endtask
  // break pin held at its active high level for a few clocks
  task automatic trip();
    @(posedge clk);
    brk_in <= 1'b1;
    repeat (6) @(posedge clk);
    brk_in <= 1'b0;
  endtask
endmodule

// ### design/tbc_defs.svh
// register offsets, field positions, reset values and rule summary for the timer core
//
// Summary of operation
// - a programmable prescaler divides the timer clock into counter ticks
// - counting up, reaching the auto-reload value restarts the counter from zero
// - counting down, reaching zero reloads the auto-reload value and restarts
// - restart raises an update only at repetition zero, else decrements repetition
// - every update event reloads the repetition counter from repetition_value
// - without repetition hardware every restart raises an update event
// - output-mode channels compare their compare value with the counter continuously
// - the reference output follows the comparison and the selected output sub-mode
// - output stage applies polarity and dead time; complementary outputs set independently
// - channel inputs are filtered, rejecting pulses shorter than the set length
// - active edge is rising, falling or both, chosen by channel polarity bits
// - each input yields own-polarity and pair-polarity edges, cross-routed to the pair
// - direction select 00 means output, other values choose one of three inputs
// - channel mode bits mean different things in input and output mode
// - channel prescaler divides active edges; each output edge captures the counter
// - with capture ratio one the captured value is the latest edge timestamp
// - an active break edge turns outputs off or forces their safe levels
// - break exists only when complementary outputs exist
// - update event sets update_flag; software clears it by writing and polls
// - a capture sets the channel capture_flag; software clears it and polls
// - direction select is writable only while the channel is disabled
// - output mode 111 is pulse width mode two; preload and divider reset to 0
`ifndef TBC_DEFS_SVH
`define TBC_DEFS_SVH

// byte offsets of the register words
`define TBC_CTRL_OFS  8'h00
`define TBC_STAT_OFS  8'h04
`define TBC_CNT_OFS   8'h08
`define TBC_PSC_OFS   8'h0C
`define TBC_ARR_OFS   8'h10
`define TBC_REP_OFS   8'h14
`define TBC_CMC_OFS   8'h18
`define TBC_CEP_OFS   8'h1C
`define TBC_CCR0_OFS  8'h20
`define TBC_CCR1_OFS  8'h24
`define TBC_BRK_OFS   8'h28

// control word bits
`define TBC_CTRL_CEN  0
`define TBC_CTRL_DIR  1
`define TBC_CTRL_ARPE 2
// status word bits: update, capture 0, capture 1, break
`define TBC_STAT_UPD  0
`define TBC_STAT_CAP0 1
`define TBC_STAT_BRK  3
// break word bits
`define TBC_BRK_EN    0
`define TBC_BRK_POL   1
`define TBC_BRK_MOE   2
`define TBC_BRK_SAFE  3
`define TBC_BRK_LVL   4
`define TBC_BRK_DT    8
// per channel: 8 mode bits, 4 enable/polarity bits
`define TBC_CMC_W     8
`define TBC_CEP_W     4

// reset values
`define TBC_ARR_RST   16'hFFFF
`define TBC_PSC_RST   16'h0000
`define TBC_CMC_RST   16'h0000
`define TBC_BRK_RST   16'h0004

`endif

// ### design/tbc_pkg.sv
// types shared by the timer core
package tbc_pkg;

  // output compare sub-modes
  typedef enum logic [2:0] {
    TBC_OC_FROZEN = 3'b000,
    TBC_OC_SETM   = 3'b001,
    TBC_OC_CLRM   = 3'b010,
    TBC_OC_TOGM   = 3'b011,
    TBC_OC_FLOW   = 3'b100,
    TBC_OC_FHIGH  = 3'b101,
    TBC_OC_PULSE_WIDTH_MODE_ONE   = 3'b110,
    TBC_OC_PULSE_WIDTH_MODE_TWO   = 3'b111
  } tbc_ocmode_e;

  // channel direction select
  typedef enum logic [1:0] {
    TBC_DIR_OUT  = 2'b00,
    TBC_DIR_OWN  = 2'b01,
    TBC_DIR_PAIR = 2'b10,
    TBC_DIR_AUX  = 2'b11
  } tbc_dir_e;

  // bus slave data phase states
  typedef enum logic [1:0] {
    TBC_BUS_IDLE  = 2'b00,
    TBC_BUS_WDATA = 2'b01,
    TBC_BUS_RWAIT = 2'b10,
    TBC_BUS_RDATA = 2'b11
  } tbc_bus_e;

endpackage

// ### design/tbc_timer.sv
// timer core: time base, two capture/compare channels, break, ahb-lite slave
`include "tbc_defs.svh"

module tbc_timer
  import tbc_pkg::*;
#(
  parameter int CW       = 16,
  parameter int RW       = 8,
  parameter bit HAS_REP  = 1'b1,
  parameter bit HAS_COMP = 1'b1
)(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic [1:0]  ch_in,
  input  wire logic [1:0]  aux_in,
  input  wire logic        brk_in,
  output logic      [1:0]  ch_out,
  output logic      [1:0]  ch_oe,
  output logic      [1:0]  ch_out_n,
  output logic      [1:0]  ch_oe_n
);

  // ---------------------------------------------------------------
  // registers and shared signals
  // ---------------------------------------------------------------
  tbc_bus_e       bus_st_r;
  logic [7:0]     a_r;
  logic [31:0]    hrdata_r;
  logic           hreadyout_r;
  logic           hresp_r;
  logic [31:0]    rd_mux;
  logic           acc;
  logic           wr_stb;
  logic [2:0]     ctrl_r;
  logic [3:0]     sts_r;
  logic [CW-1:0]  cnt_r;
  logic [CW-1:0]  psc_r;
  logic [CW-1:0]  psc_act_r;
  logic [CW-1:0]  psc_cnt_r;
  logic [CW-1:0]  arr_r;
  logic [CW-1:0]  arr_act_r;
  logic [CW-1:0]  arr_use;
  logic [RW-1:0]  rep_r;
  logic [RW-1:0]  rep_cnt_r;
  logic [15:0]    cmc_r;
  logic [7:0]     cep_r;
  logic [15:0]    brk_r;
  logic [4:0]     sync1_r;
  logic [4:0]     sync2_r;
  logic           brk_d_r;
  logic           brk_hit;
  logic           tick;
  logic           tick_d_r;
  logic           restart;
  logic           uev;
  logic           moe_eff;
  logic [1:0]     fp_own;
  logic [1:0]     fp_pair;
  logic [1:0]     cap_ev;
  logic [1:0]     ccr_wr;
  logic [CW-1:0]  ccr_rd [2];

  // active edge selection from polarity bits {np,p}
  function automatic logic edge_sel(input logic r, input logic f, input logic [1:0] pol);
    logic e;
    e = 1'b0;
    case (pol)
      2'b01:   e = f;
      2'b11:   e = r | f;
      default: e = r;
    endcase
    return e;
  endfunction

  // ---------------------------------------------------------------
  // ahb-lite slave: zero-wait writes, one wait state on reads
  // ---------------------------------------------------------------
  assign acc    = hsel & htrans[1] & hready;
  assign wr_stb = (bus_st_r == TBC_BUS_WDATA);
  assign hrdata    = hrdata_r;
  assign hreadyout = hreadyout_r;
  assign hresp     = hresp_r;

  // read data registered so that every bus output comes from a flop
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bus_st_r    <= TBC_BUS_IDLE;
      a_r         <= 8'h00;
      hrdata_r    <= 32'h00000000;
      hreadyout_r <= 1'b1;
      hresp_r     <= 1'b0;
    end else begin
      case (bus_st_r)
        TBC_BUS_RWAIT: begin
          hrdata_r    <= rd_mux;
          hreadyout_r <= 1'b1;
          bus_st_r    <= TBC_BUS_RDATA;
        end
        default: begin
          if (acc) begin
            a_r         <= haddr[7:0];
            hreadyout_r <= hwrite;
            bus_st_r    <= hwrite ? TBC_BUS_WDATA : TBC_BUS_RWAIT;
          end else begin
            bus_st_r <= TBC_BUS_IDLE;
          end
        end
      endcase
    end
  end

  // read multiplexer; unmapped words read as zero
  always_comb begin
    rd_mux = 32'h00000000;
    case (a_r)
      `TBC_CTRL_OFS: rd_mux[2:0]    = ctrl_r;
      `TBC_STAT_OFS: rd_mux[3:0]    = sts_r;
      `TBC_CNT_OFS:  rd_mux[CW-1:0] = cnt_r;
      `TBC_PSC_OFS:  rd_mux[CW-1:0] = psc_r;
      `TBC_ARR_OFS:  rd_mux[CW-1:0] = arr_r;
      `TBC_REP_OFS:  rd_mux[RW-1:0] = rep_r;
      `TBC_CMC_OFS:  rd_mux[15:0]   = cmc_r;
      `TBC_CEP_OFS:  rd_mux[7:0]    = cep_r;
      `TBC_CCR0_OFS: rd_mux[CW-1:0] = ccr_rd[0];
      `TBC_CCR1_OFS: rd_mux[CW-1:0] = ccr_rd[1];
      `TBC_BRK_OFS:  rd_mux[15:0]   = brk_r;
      default:       rd_mux = 32'h00000000;
    endcase
  end

  assign ccr_wr[0] = wr_stb & (a_r == `TBC_CCR0_OFS);
  assign ccr_wr[1] = wr_stb & (a_r == `TBC_CCR1_OFS);

  // ---------------------------------------------------------------
  // plain software registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_r <= 3'h0;
      psc_r  <= `TBC_PSC_RST;
      arr_r  <= `TBC_ARR_RST;
      rep_r  <= '0;
      cep_r  <= 8'h00;
    end else if (wr_stb) begin
      case (a_r)
        `TBC_CTRL_OFS: ctrl_r <= hwdata[2:0];
        `TBC_PSC_OFS:  psc_r  <= hwdata[CW-1:0];
        `TBC_ARR_OFS:  arr_r  <= hwdata[CW-1:0];
        `TBC_REP_OFS:  rep_r  <= hwdata[RW-1:0];
        `TBC_CEP_OFS:  cep_r  <= hwdata[7:0];
        default: ;
      endcase
    end
  end

  // mode word; direction bits frozen while the channel is enabled
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cmc_r <= `TBC_CMC_RST;
    end else if (wr_stb && a_r == `TBC_CMC_OFS) begin
      for (int g = 0; g < 2; g++) begin
        cmc_r[g*8+2 +: 6] <= hwdata[g*8+2 +: 6];
        if (!cep_r[g*`TBC_CEP_W]) begin
          cmc_r[g*8 +: 2] <= hwdata[g*8 +: 2];
        end
      end
    end
  end

  // break word; a break clears main output enable, and that wins
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      brk_r <= `TBC_BRK_RST;
    end else if (brk_hit) begin
      brk_r[`TBC_BRK_MOE] <= 1'b0;
    end else if (wr_stb && a_r == `TBC_BRK_OFS) begin
      brk_r <= hwdata[15:0];
    end
  end

  // status flags: writing 0 clears a bit, a same-cycle set wins
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sts_r <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (wr_stb && a_r == `TBC_STAT_OFS && !hwdata[i]) begin
          sts_r[i] <= 1'b0;
        end
      end
      if (uev) sts_r[`TBC_STAT_UPD] <= 1'b1;
      if (cap_ev[0]) sts_r[`TBC_STAT_CAP0] <= 1'b1;
      if (cap_ev[1]) sts_r[`TBC_STAT_CAP0+1] <= 1'b1;
      if (brk_hit) sts_r[`TBC_STAT_BRK] <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // pin synchronisers and break detection
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sync1_r <= 5'h00;
      sync2_r <= 5'h00;
      brk_d_r <= 1'b0;
    end else begin
      sync1_r <= {brk_in, aux_in, ch_in};
      sync2_r <= sync1_r;
      brk_d_r <= (sync2_r[4] == brk_r[`TBC_BRK_POL]);
    end
  end

  // break logic exists only alongside complementary outputs
  assign brk_hit = HAS_COMP & brk_r[`TBC_BRK_EN]
                 & (sync2_r[4] == brk_r[`TBC_BRK_POL]) & ~brk_d_r;
  // outputs go safe in the same edge that the break is seen
  assign moe_eff = brk_r[`TBC_BRK_MOE] & ~brk_hit;

  // ---------------------------------------------------------------
  // time base
  // ---------------------------------------------------------------
  assign arr_use = ctrl_r[`TBC_CTRL_ARPE] ? arr_act_r : arr_r;
  assign tick    = ctrl_r[`TBC_CTRL_CEN] & (psc_cnt_r == psc_act_r);
  assign restart = tick & (ctrl_r[`TBC_CTRL_DIR] ? (cnt_r == '0)
                                                 : (cnt_r >= arr_use));
  // missing repetition hardware reads as a permanent zero
  assign uev = restart & (!HAS_REP || rep_cnt_r == '0);

  // prescaler; its divide value only takes effect at an update
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      psc_cnt_r <= '0;
      psc_act_r <= `TBC_PSC_RST;
      arr_act_r <= `TBC_ARR_RST;
      tick_d_r  <= 1'b0;
    end else begin
      tick_d_r <= tick;
      if (tick) begin
        psc_cnt_r <= '0;
      end else if (ctrl_r[`TBC_CTRL_CEN]) begin
        psc_cnt_r <= psc_cnt_r + 1'b1;
      end
      if (uev) begin
        psc_act_r <= psc_r;
        arr_act_r <= arr_r;
      end
    end
  end

  // main counter; frozen while disabled
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= '0;
    end else if (wr_stb && a_r == `TBC_CNT_OFS) begin
      cnt_r <= hwdata[CW-1:0];
    end else if (tick) begin
      if (restart) begin
        cnt_r <= ctrl_r[`TBC_CTRL_DIR] ? arr_use : '0;
      end else if (ctrl_r[`TBC_CTRL_DIR]) begin
        cnt_r <= cnt_r - 1'b1;
      end else begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end

  // repetition counter
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rep_cnt_r <= '0;
    end else if (HAS_REP && restart) begin
      if (uev) begin
        rep_cnt_r <= rep_r;
      end else begin
        rep_cnt_r <= rep_cnt_r - 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // channels; the pair is channel 0 and channel 1
  // ---------------------------------------------------------------
  for (genvar g = 0; g < 2; g++) begin : gch
    localparam int Z = 1 - g;
    tbc_dir_e      dsel;
    tbc_ocmode_e   ocm;
    logic [3:0]    flt_n;
    logic [1:0]    cpsc;
    logic          pe;
    logic [1:0]    pol_own;
    logic [1:0]    pol_pair;
    logic          en;
    logic          filt_r;
    logic          filt_d_r;
    logic [3:0]    fcnt_r;
    logic          aux_d_r;
    logic          rise;
    logic          fall;
    logic          src;
    logic [2:0]    ccnt_r;
    logic [2:0]    cmask;
    logic [CW-1:0] ccr_pre_r;
    logic [CW-1:0] ccr_act_r;
    logic          ref_r;
    logic          ref_d_r;
    logic [7:0]    dtc_r;
    logic          o_r;
    logic          oe_r;
    logic          on_r;
    logic          oen_r;
    logic          lt;
    logic          hit;

    // same mode bits read as compare or capture fields
    assign dsel     = tbc_dir_e'(cmc_r[g*8 +: 2]);
    assign pe       = cmc_r[g*8+2];
    assign cpsc     = cmc_r[g*8+2 +: 2];
    assign ocm      = tbc_ocmode_e'(cmc_r[g*8+4 +: 3]);
    assign flt_n    = cmc_r[g*8+4 +: 4];
    assign en       = cep_r[g*4];
    assign pol_own  = {cep_r[g*4+3], cep_r[g*4+1]};
    assign pol_pair = {cep_r[Z*4+3], cep_r[Z*4+1]};
    assign ccr_rd[g] = (dsel == TBC_DIR_OUT) ? ccr_pre_r : ccr_act_r;

    // filter: level must hold flt_n+1 samples before it is accepted
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        filt_r   <= 1'b0;
        filt_d_r <= 1'b0;
        fcnt_r   <= 4'h0;
        aux_d_r  <= 1'b0;
      end else begin
        filt_d_r <= filt_r;
        aux_d_r  <= sync2_r[2+g];
        if (sync2_r[g] == filt_r) begin
          fcnt_r <= 4'h0;
        end else if (fcnt_r >= flt_n) begin
          filt_r <= sync2_r[g];
          fcnt_r <= 4'h0;
        end else begin
          fcnt_r <= fcnt_r + 4'h1;
        end
      end
    end

    assign rise = filt_r & ~filt_d_r;
    assign fall = ~filt_r & filt_d_r;
    assign fp_own[g]  = edge_sel(rise, fall, pol_own);
    assign fp_pair[g] = edge_sel(rise, fall, pol_pair);

    // capture source multiplexer; pair edge comes from the other input
    always_comb begin
      case (dsel)
        TBC_DIR_OWN:  src = fp_own[g];
        TBC_DIR_PAIR: src = fp_pair[Z];
        TBC_DIR_AUX:  src = edge_sel(sync2_r[2+g] & ~aux_d_r,
                                     ~sync2_r[2+g] & aux_d_r, pol_own);
        default:      src = 1'b0;
      endcase
    end

    // capture prescaler: every 1, 2, 4 or 8 edges
    assign cmask     = (3'h1 << cpsc) - 3'h1;
    assign cap_ev[g] = en & src & (ccnt_r == cmask);

    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        ccnt_r <= 3'h0;
      end else if (!en || dsel == TBC_DIR_OUT) begin
        ccnt_r <= 3'h0;
      end else if (src) begin
        ccnt_r <= cap_ev[g] ? 3'h0 : ccnt_r + 3'h1;
      end
    end

    // compare/capture value; preload copies to the active one at update
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        ccr_pre_r <= '0;
        ccr_act_r <= '0;
      end else if (cap_ev[g]) begin
        ccr_pre_r <= cnt_r;
        ccr_act_r <= cnt_r;
      end else if (ccr_wr[g]) begin
        ccr_pre_r <= hwdata[CW-1:0];
        if (!pe || dsel != TBC_DIR_OUT) ccr_act_r <= hwdata[CW-1:0];
      end else if (uev && pe) begin
        ccr_act_r <= ccr_pre_r;
      end
    end

    // reference output; match events only once per counter step
    assign lt  = (cnt_r < ccr_act_r);
    assign hit = tick_d_r & (cnt_r == ccr_act_r);

    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        ref_r <= 1'b0;
      end else if (dsel != TBC_DIR_OUT) begin
        ref_r <= 1'b0;
      end else begin
        case (ocm)
          TBC_OC_SETM:  if (hit) ref_r <= 1'b1;
          TBC_OC_CLRM:  if (hit) ref_r <= 1'b0;
          TBC_OC_TOGM:  if (hit) ref_r <= ~ref_r;
          TBC_OC_FLOW:  ref_r <= 1'b0;
          TBC_OC_FHIGH: ref_r <= 1'b1;
          TBC_OC_PULSE_WIDTH_MODE_ONE:  ref_r <= lt;
          TBC_OC_PULSE_WIDTH_MODE_TWO:  ref_r <= ~lt;
          default:      ref_r <= ref_r;
        endcase
      end
    end

    // dead time: both outputs idle for dt cycles after each ref change
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        ref_d_r <= 1'b0;
        dtc_r   <= 8'h00;
      end else begin
        ref_d_r <= ref_r;
        if (ref_r != ref_d_r) begin
          dtc_r <= brk_r[`TBC_BRK_DT +: 8];
        end else if (dtc_r != 8'h00) begin
          dtc_r <= dtc_r - 8'h01;
        end
      end
    end

    // output stage: polarity and enable per output, break override
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        o_r   <= 1'b0;
        oe_r  <= 1'b0;
        on_r  <= 1'b0;
        oen_r <= 1'b0;
      end else if (dsel != TBC_DIR_OUT) begin
        o_r   <= 1'b0;
        oe_r  <= 1'b0;
        on_r  <= 1'b0;
        oen_r <= 1'b0;
      end else if (!moe_eff) begin
        // safe mode drives the idle levels, otherwise outputs float off
        o_r   <= brk_r[`TBC_BRK_SAFE] & brk_r[`TBC_BRK_LVL+2*g];
        oe_r  <= brk_r[`TBC_BRK_SAFE] & en;
        on_r  <= brk_r[`TBC_BRK_SAFE] & brk_r[`TBC_BRK_LVL+2*g+1];
        oen_r <= brk_r[`TBC_BRK_SAFE] & HAS_COMP & cep_r[g*4+2];
      end else begin
        o_r   <= en & ((ref_r & dtc_r == 8'h00) ^ cep_r[g*4+1]);
        oe_r  <= en;
        on_r  <= HAS_COMP & cep_r[g*4+2]
               & ((~ref_r & dtc_r == 8'h00) ^ cep_r[g*4+3]);
        oen_r <= HAS_COMP & cep_r[g*4+2];
      end
    end

    assign ch_out[g]   = o_r;
    assign ch_oe[g]    = oe_r;
    assign ch_out_n[g] = on_r;
    assign ch_oe_n[g]  = oen_r;
  end

endmodule
